// [core/fosc_pkg.sv]
/*
  fosc_pkg: constants, register map and carrier types of the fan output
  sequencer controller.
  Assumes a single 25 MHz core clock and a simple strobe register port.
*/
//
// Contract
// - mode key toggles automatic and manual
// - manual mode starts outputs one at a time
// - manual delay minimum and default 10 s
// - delay edited per digit, enter stores
// - automatic delay comes from remote register
// - overload lights led, displays, reports upstream
// - clear-one key clears one, clear-all clears all
// - persisting fault raises warning again
// - blown fuse latched and cleared like overload
// - idle blanks screen, leds cycle, key wakes
// - automatic without gateway: outputs off after 60 min
// - manual mode bypasses network loss shutdown
// - gateway seen again resumes automatic by itself
// - display mode, strength, no-gateway, no-network
// - down key shows per-channel diagnostic bits
// - builds with 12 or 6 outputs
// - strength percent from latest received packet
// - single channel: clear key, strength icon
package fosc_pkg;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_HZ         = 25_000_000;       // core clock rate
  localparam int TICK_S         = 1;                // timebase period, s
  localparam int TICK_CYCLES    = CLK_HZ * TICK_S;  // cycles per timebase
  localparam int DELAY_MIN_S    = 10;               // manual delay floor
  localparam int NETLOSS_MIN    = 60;               // loss shutdown, min
  localparam int NETLOSS_S      = NETLOSS_MIN * 60; // same, in seconds
  localparam int SAVER_S        = 300;              // idle before blanking
  localparam int STARTUP_S      = 3;                // start-up info shown
  localparam int MAX_CH         = 12;

  // -----------------------------------------------------------------
  // register map, byte addresses
  // -----------------------------------------------------------------
  localparam logic [7:0] REG_REMOTE_CMD = 8'h00;
  localparam logic [7:0] REG_AUTO_DLY   = 8'h04;
  localparam logic [7:0] REG_RSSI       = 8'h08;
  localparam logic [7:0] REG_STATUS     = 8'h0c;
  localparam logic [7:0] REG_WARN       = 8'h10;
  localparam logic [7:0] REG_DIAG_IN    = 8'h14;
  localparam logic [7:0] REG_DIAG_OUT   = 8'h18;
  localparam logic [7:0] REG_DIAG_FUSE  = 8'h1c;
  localparam logic [7:0] REG_MAN_DLY    = 8'h20;

  localparam logic [15:0] AUTO_DLY_RST  = 16'h000a;
  localparam logic [11:0] MAN_BCD_RST   = 12'h010;   // 10 s in bcd
  localparam int WARN_FUSE_LSB          = 16;

  // status bit positions
  localparam int ST_MANUAL   = 0;
  localparam int ST_GW       = 1;
  localparam int ST_NET      = 2;
  localparam int ST_SHUTDOWN = 3;
  localparam int ST_SCREEN   = 4;
  localparam int ST_EDITING  = 5;

  // signal icon thresholds in percent
  localparam logic [7:0] ICON_T1 = 8'h19;
  localparam logic [7:0] ICON_T2 = 8'h32;
  localparam logic [7:0] ICON_T3 = 8'h4b;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef struct packed {
    logic mode;
    logic clear_one_warning_key;
    logic clear_all_warnings_key;
    logic clear_key;
    logic enter;
    logic up;
    logic down;
    logic left;
    logic right;
  } fosc_keys_t;

  typedef enum logic [1:0] {
    PG_START = 2'b00,
    PG_HOME  = 2'b01,
    PG_DIAG  = 2'b10,
    PG_DELAY = 2'b11
  } fosc_page_t;

  typedef struct packed {
    fosc_page_t  page;
    logic        blank;
    logic        manual;
    logic        no_gateway;
    logic        no_network;
    logic [7:0]  pct;
    logic [2:0]  icon;      // 0 = cross, 1..4 = waves
    logic        editing;
    logic [1:0]  cursor;
    logic [11:0] digits;
    logic        warning;
  } fosc_disp_t;

endpackage

// [core/fosc_controller.sv]
/*
  fosc_controller: mode selection, output sequencing, warning latches,
  network loss shutdown, screen saver and display state of the fan
  output sequencer controller.
  Assumes keys, fault and presence inputs are synchronous and debounced,
  and that the register master never issues both strobes together.
*/
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module fosc_controller
  import fosc_pkg::*;
#(
  parameter int N_CH        = 12,
  parameter int TICK_CYC    = TICK_CYCLES,
  parameter int NETLOSS_SEC = NETLOSS_S,
  parameter int SAVER_SEC   = SAVER_S
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_resetn,
  input  wire logic [7:0]       i_addr,
  input  wire logic [31:0]      i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [31:0]      o_rdata,
  input  wire fosc_keys_t       i_keys,
  input  wire logic             i_gw_seen,
  input  wire logic             i_net_seen,
  input  wire logic [N_CH-1:0]  i_overload,
  input  wire logic [N_CH-1:0]  i_fuse_blown,
  input  wire logic [N_CH-1:0]  i_fan_run,
  output logic      [N_CH-1:0]  o_fan_on,
  output logic                  o_warn_led,
  output logic                  o_warn_event,
  output logic      [2:0]       o_led_cycle,
  output fosc_disp_t            o_disp
);

  // -----------------------------------------------------------------
  // elaboration checks
  // -----------------------------------------------------------------
  generate
    if (!(N_CH == 1 || N_CH == 6 || N_CH == 12)) begin : g_bad_ch
      $error("N_CH must be 1, 6 or 12");
    end
    if (TICK_CYC < 1 || NETLOSS_SEC < 1 || SAVER_SEC < 1 || NETLOSS_SEC > 65535) begin : g_bad_time
      $error("timing parameters out of range");
    end
  endgenerate

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]     rdata;
    logic [N_CH-1:0] remote_cmd;
    logic [15:0]     auto_dly;
    logic [7:0]      rssi;
    logic            manual;
    fosc_keys_t      keys_prev;
    logic [31:0]     tick_cnt;
    logic [15:0]     seq_cnt;
    logic            seq_wait;
    logic [15:0]     loss_s;
    logic            shutdown;
    logic [15:0]     idle_s;
    logic            blank;
    logic [2:0]      led;
    logic [7:0]      start_s;
    fosc_page_t      page;
    logic            editing;
    logic [1:0]      cursor;
    logic [11:0]     digits;
    logic [11:0]     man_bcd;
    logic [N_CH-1:0] ovl;
    logic [N_CH-1:0] fuse;
    logic            warn_evt;
    logic            warn_led;
    logic [N_CH-1:0] fan;
    fosc_disp_t      disp;
  } fosc_state_t;

  fosc_state_t s_r;
  fosc_state_t s_nxt;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // isolate the lowest set bit; used for clear-one and next output
  function automatic logic [2*MAX_CH-1:0] lsb_onehot(input logic [2*MAX_CH-1:0] v);
    lsb_onehot = v & (~v + 24'h000001);
  endfunction

  // three bcd digits to seconds
  function automatic logic [15:0] bcd_to_s(input logic [11:0] b);
    bcd_to_s = 16'(b[11:8]) * 16'h0064 + 16'(b[7:4]) * 16'h000a + 16'(b[3:0]);
  endfunction

  // step one bcd digit up or down with wrap
  function automatic logic [11:0] bcd_step(input logic [11:0] b, input logic [1:0] pos, input logic up);
    logic [3:0]  d;
    logic [11:0] r;
    r = b;
    d = b[4*pos +: 4];
    if (up) begin
      d = (d == 4'h9) ? 4'h0 : d + 4'h1;
    end else begin
      d = (d == 4'h0) ? 4'h9 : d - 4'h1;
    end
    r[4*pos +: 4] = d;
    bcd_step = r;
  endfunction

  // strength icon: cross with no link, else wave count
  function automatic logic [2:0] rssi_icon(input logic [7:0] pct, input logic link);
    if (!link) begin
      rssi_icon = 3'h0;
    end else if (pct < ICON_T1) begin
      rssi_icon = 3'h1;
    end else if (pct < ICON_T2) begin
      rssi_icon = 3'h2;
    end else if (pct < ICON_T3) begin
      rssi_icon = 3'h3;
    end else begin
      rssi_icon = 3'h4;
    end
  endfunction

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    fosc_keys_t              press;
    fosc_keys_t              act;
    logic                    tick;
    logic                    lost;
    logic [2*MAX_CH-1:0]     w;
    logic [2*MAX_CH-1:0]     w_old;
    logic [N_CH-1:0]         target;
    logic [N_CH-1:0]         pending;
    logic [15:0]             dly;
    logic [15:0]             man_s;
    logic [2*MAX_CH-1:0]     first;
    press   = '0;
    act     = '0;
    tick    = 1'b0;
    lost    = 1'b0;
    w       = '0;
    w_old   = '0;
    target  = '0;
    pending = '0;
    dly     = '0;
    man_s   = '0;
    first   = '0;
    s_nxt   = s_r;

    // timebase: one-cycle pulse per second
    tick = (s_r.tick_cnt == 32'(TICK_CYC - 1));
    s_nxt.tick_cnt = tick ? 32'h0 : s_r.tick_cnt + 32'h1;

    // key edges; levels are held by the keypad
    press = i_keys & ~s_r.keys_prev;
    s_nxt.keys_prev = i_keys;

    // screen saver; a wake-up press is swallowed so it cannot flip
    // the mode by accident while the screen is dark
    if (|press) begin
      s_nxt.idle_s = 16'h0;
      s_nxt.blank  = 1'b0;
      act          = s_r.blank ? fosc_keys_t'('0) : press;
    end else if (tick && !s_r.blank) begin
      if (s_r.idle_s == 16'(SAVER_SEC - 1)) begin
        s_nxt.blank = 1'b1;
      end else begin
        s_nxt.idle_s = s_r.idle_s + 16'h1;
      end
    end
    if (s_nxt.blank) begin
      if (tick || s_r.led == 3'h0) begin
        s_nxt.led = (s_r.led == 3'h0) ? 3'h1 : {s_r.led[1:0], s_r.led[2]};
      end
    end else begin
      s_nxt.led = 3'h0;
    end

    // mode key
    if (act.mode) begin
      s_nxt.manual = ~s_r.manual;
    end

    // pages and delay editor
    man_s = bcd_to_s(s_r.man_bcd);
    case (s_r.page)
      PG_START: begin
        if (tick) begin
          if (s_r.start_s == 8'(STARTUP_S - 1)) begin
            s_nxt.page = PG_HOME;
          end else begin
            s_nxt.start_s = s_r.start_s + 8'h1;
          end
        end
      end
      PG_HOME: begin
        if (act.down) begin
          s_nxt.page = PG_DIAG;
        end else if (act.right) begin
          s_nxt.page = PG_DELAY;
        end
      end
      PG_DIAG: begin
        if (act.up) begin
          s_nxt.page = PG_HOME;
        end
      end
      PG_DELAY: begin
        if (!s_r.editing) begin
          if (act.enter) begin
            s_nxt.editing = 1'b1;
            s_nxt.digits  = s_r.man_bcd;
            s_nxt.cursor  = 2'h0;
          end else if (act.left) begin
            s_nxt.page = PG_HOME;
          end
        end else if (act.enter) begin
          s_nxt.editing = 1'b0;
          if (bcd_to_s(s_r.digits) < 16'(DELAY_MIN_S)) begin
            s_nxt.man_bcd = MAN_BCD_RST;
          end else begin
            s_nxt.man_bcd = s_r.digits;
          end
        end else if (act.left) begin
          s_nxt.cursor = (s_r.cursor == 2'h2) ? 2'h2 : s_r.cursor + 2'h1;
        end else if (act.right) begin
          s_nxt.cursor = (s_r.cursor == 2'h0) ? 2'h0 : s_r.cursor - 2'h1;
        end else if (act.up || act.down) begin
          s_nxt.digits = bcd_step(s_r.digits, s_r.cursor, act.up);
        end
      end
      default: begin
        s_nxt.page = PG_HOME;
      end
    endcase

    // warnings: clear first, then the live condition sets again so a
    // fault that persists or arrives with the clear is never lost
    w_old = {(2*MAX_CH)'(s_r.fuse) << MAX_CH} | (2*MAX_CH)'(s_r.ovl);
    w     = w_old;
    if (act.clear_all_warnings_key || act.clear_key) begin
      w = '0;
    end else if (act.clear_one_warning_key) begin
      w = w & ~lsb_onehot(w);
    end
    w = w | ((2*MAX_CH)'(i_fuse_blown) << MAX_CH) | (2*MAX_CH)'(i_overload);
    s_nxt.ovl      = w[N_CH-1:0];
    s_nxt.fuse     = w[MAX_CH +: N_CH];
    s_nxt.warn_evt = |(w & ~w_old);
    s_nxt.warn_led = |w;

    // network loss; manual mode clears and bypasses the timer
    lost = ~i_gw_seen | ~i_net_seen;
    if (!lost || s_nxt.manual) begin
      s_nxt.loss_s   = 16'h0;
      s_nxt.shutdown = 1'b0;
    end else if (tick && !s_r.shutdown) begin
      if (s_r.loss_s == 16'(NETLOSS_SEC)) begin
        s_nxt.shutdown = 1'b1;
      end else begin
        s_nxt.loss_s = s_r.loss_s + 16'h1;
      end
    end

    // output sequencer: stops at once, starts one at a time
    if (s_nxt.manual) begin
      target = '1;
      dly    = man_s;
    end else begin
      target = s_nxt.shutdown ? '0 : s_r.remote_cmd;
      dly    = s_r.auto_dly;
    end
    s_nxt.fan = s_r.fan & target;
    pending   = target & ~s_r.fan;
    if (s_r.seq_wait) begin
      // first tick after a start is partial, so one extra is waited
      if (tick) begin
        if (s_r.seq_cnt >= dly) begin
          s_nxt.seq_wait = 1'b0;
        end else begin
          s_nxt.seq_cnt = s_r.seq_cnt + 16'h1;
        end
      end
    end else if (|pending) begin
      first          = lsb_onehot((2*MAX_CH)'(pending));
      s_nxt.fan      = s_nxt.fan | first[N_CH-1:0];
      s_nxt.seq_wait = 1'b1;
      s_nxt.seq_cnt  = 16'h0;
    end

    // register writes
    if (i_wr) begin
      case (i_addr)
        REG_REMOTE_CMD: s_nxt.remote_cmd = i_wdata[N_CH-1:0];
        REG_AUTO_DLY:   s_nxt.auto_dly   = i_wdata[15:0];
        REG_RSSI:       s_nxt.rssi       = i_wdata[7:0];
        default:        s_nxt.rssi       = s_nxt.rssi;
      endcase
    end

    // register reads: data valid the cycle after the strobe only
    s_nxt.rdata = 32'h0;
    if (i_rd) begin
      case (i_addr)
        REG_REMOTE_CMD: s_nxt.rdata = 32'(s_r.remote_cmd);
        REG_AUTO_DLY:   s_nxt.rdata = 32'(s_r.auto_dly);
        REG_RSSI:       s_nxt.rdata = 32'(s_r.rssi);
        REG_STATUS: begin
          s_nxt.rdata[ST_MANUAL]   = s_r.manual;
          s_nxt.rdata[ST_GW]       = i_gw_seen;
          s_nxt.rdata[ST_NET]      = i_net_seen;
          s_nxt.rdata[ST_SHUTDOWN] = s_r.shutdown;
          s_nxt.rdata[ST_SCREEN]   = ~s_r.blank;
          s_nxt.rdata[ST_EDITING]  = s_r.editing;
        end
        REG_WARN:      s_nxt.rdata = (32'(s_r.fuse) << WARN_FUSE_LSB) | 32'(s_r.ovl);
        REG_DIAG_IN:   s_nxt.rdata = 32'(i_fan_run);
        REG_DIAG_OUT:  s_nxt.rdata = 32'(s_r.fan);
        REG_DIAG_FUSE: s_nxt.rdata = 32'(i_fuse_blown);
        REG_MAN_DLY:   s_nxt.rdata = 32'(man_s);
        default:       s_nxt.rdata = 32'h0;
      endcase
    end

    // display picture, taken from the next state
    s_nxt.disp.page       = s_nxt.page;
    s_nxt.disp.blank      = s_nxt.blank;
    s_nxt.disp.manual     = s_nxt.manual;
    s_nxt.disp.no_gateway = ~i_gw_seen;
    s_nxt.disp.no_network = i_gw_seen & ~i_net_seen;
    s_nxt.disp.pct        = s_nxt.rssi;
    s_nxt.disp.icon       = rssi_icon(s_nxt.rssi, ~lost);
    s_nxt.disp.editing    = s_nxt.editing;
    s_nxt.disp.cursor     = s_nxt.cursor;
    s_nxt.disp.digits     = s_nxt.editing ? s_nxt.digits : s_nxt.man_bcd;
    s_nxt.disp.warning    = s_nxt.warn_led;
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r          <= '0;
      s_r.auto_dly <= AUTO_DLY_RST;
      s_r.man_bcd  <= MAN_BCD_RST;
      s_r.page     <= PG_START;
      s_r.disp     <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign o_rdata      = s_r.rdata;
  assign o_fan_on     = s_r.fan;
  assign o_warn_led   = s_r.warn_led;
  assign o_warn_event = s_r.warn_evt;
  assign o_led_cycle  = s_r.led;
  assign o_disp       = s_r.disp;

endmodule

`default_nettype wire

// [testbench/fosc_controller_asserts.sv]
/*
  fosc_controller_asserts: port-level checks of the fan output sequencer.
  Assumes it is bound onto fosc_controller and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none

module fosc_controller_asserts
  import fosc_pkg::*;
#(
  parameter int N_CH        = 12,
  parameter int TICK_CYC    = TICK_CYCLES,
  parameter int NETLOSS_SEC = NETLOSS_S,
  parameter int SAVER_SEC   = SAVER_S
) (
  input wire logic            i_core_clk,
  input wire logic            i_resetn,
  input wire logic            i_rd,
  input wire logic [31:0]     o_rdata,
  input wire fosc_keys_t      i_keys,
  input wire logic            i_gw_seen,
  input wire logic            i_net_seen,
  input wire logic [N_CH-1:0] i_overload,
  input wire logic [N_CH-1:0] i_fuse_blown,
  input wire logic [N_CH-1:0] o_fan_on,
  input wire logic            o_warn_led,
  input wire logic            o_warn_event,
  input wire logic [2:0]      o_led_cycle,
  input wire fosc_disp_t      o_disp
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  // -------------------------------------------------------------------
  // helper counters
  // -------------------------------------------------------------------
  logic [N_CH-1:0] prev_on_r;
  logic [15:0]     gap_r;
  logic [15:0]     lost_r;
  logic            seen_r;
  logic [N_CH-1:0] rise_w;

  assign rise_w = o_fan_on & ~prev_on_r;

  // gap only counts inside manual runs, so the first start after a toggle is free
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_on_r <= '0;
      gap_r     <= '0;
      lost_r    <= '0;
      seen_r    <= 1'b0;
    end else begin
      prev_on_r <= o_fan_on;
      seen_r    <= o_disp.manual && (seen_r || (rise_w != '0));
      if (!o_disp.manual || (rise_w != '0)) begin
        gap_r <= '0;
      end else if (gap_r != 16'hffff) begin
        gap_r <= gap_r + 16'h0001;
      end
      if (o_disp.manual || (i_gw_seen && i_net_seen)) begin
        lost_r <= '0;
      end else if (lost_r != 16'hffff) begin
        lost_r <= lost_r + 16'h0001;
      end
    end
  end

  sequence s_man_start;
    (rise_w != '0) && o_disp.manual && seen_r;
  endsequence

  sequence s_wake_press;
    $rose(|i_keys) && o_disp.blank;
  endsequence

  // -------------------------------------------------------------------
  // properties
  // -------------------------------------------------------------------
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside the answer cycle");
  chk_mode_toggle: assert property ($rose(i_keys.mode) && !o_disp.blank |=>
    o_disp.manual != $past(o_disp.manual))
    else $error("mode key did not toggle the mode");
  chk_seq_single: assert property (o_disp.manual |-> $onehot0(rise_w))
    else $error("more than one output started together");
  chk_seq_gap: assert property (s_man_start |-> gap_r >= DELAY_MIN_S * TICK_CYC - 1)
    else $error("manual start came before the full delay");
  chk_manual_hold: assert property (o_disp.manual && $past(o_disp.manual) |->
    (($past(o_fan_on) & ~o_fan_on) == '0))
    else $error("output dropped in manual mode");
  chk_netloss_off: assert property (lost_r >= (NETLOSS_SEC + 2) * TICK_CYC |-> o_fan_on == '0)
    else $error("outputs still on after network loss time");
  chk_warn_raise: assert property ((i_overload != '0) || (i_fuse_blown != '0) |-> ##[1:2] o_warn_led)
    else $error("fault did not light the warning led");
  chk_warn_event: assert property (o_warn_event |-> o_warn_led)
    else $error("upstream report without a latched warning");
  chk_blank_leds: assert property (o_disp.blank && $past(o_disp.blank) |-> $onehot(o_led_cycle))
    else $error("indicator leds not cycling while blank");
  chk_key_wake: assert property (s_wake_press |=> !o_disp.blank)
    else $error("key press did not restore the screen");
  chk_gw_display: assert property ($stable(i_gw_seen) |-> o_disp.no_gateway == !i_gw_seen)
    else $error("no-gateway indication wrong");
endmodule

`default_nettype wire

// [testbench/fosc_starters_model.sv]
/*
  fosc_starters_model: fan starter contactors behind the outputs.
  Assumes the testbench commands overload trips and blown fuses.
*/
`timescale 1ns/1ps
`default_nettype none

module fosc_starters_model #(
  parameter int N_CH = 6
) (
  input  wire logic            i_core_clk,
  input  wire logic            i_resetn,
  input  wire logic [N_CH-1:0] i_fan_on,
  input  wire logic [N_CH-1:0] i_trip,
  input  wire logic [N_CH-1:0] i_fuse,
  output logic      [N_CH-1:0] o_run,
  output logic      [N_CH-1:0] o_overload,
  output logic      [N_CH-1:0] o_fuse_blown
);
  // contactor pulls in a cycle after its coil; a blown fuse keeps it open
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_run <= '0;
    end else begin
      o_run <= i_fan_on & ~i_fuse;
    end
  end
  // overload relay and fuse contacts follow the commanded faults
  assign o_overload   = i_trip;
  assign o_fuse_blown = i_fuse;
endmodule

`default_nettype wire

// [testbench/fosc_controller_tb.sv]
/*
  fosc_controller_tb: register, key and fault scenarios for the controller.
  Assumes shortened timebase parameters and a six-output build.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD %0t: got %0h exp %0h", $time, (got), (exp)); end end

module fosc_controller_tb;
  import fosc_pkg::*;
  localparam int NC = 6, TK = 4, NL = 5, SV = 20;
  localparam int K_MODE = 8, K_CLR1 = 7, K_CLRA = 6, K_CLR = 5, K_ENTER = 4;
  localparam int K_UP = 3, K_DOWN = 2, K_LEFT = 1, K_RIGHT = 0;
  logic            clk, rstn, wr, rd, gw_up, net_up, led, evt, evt_seen;
  logic [7:0]      addr;
  logic [31:0]     wdata, rdata;
  logic [8:0]      keys;
  logic [NC-1:0]   trip, fuse_cmd, ovl, fuse, run, fan_on;
  logic [2:0]      ledc;
  fosc_disp_t      disp;
  int              compares, miscompares, n;

  fosc_controller #(.N_CH(NC), .TICK_CYC(TK), .NETLOSS_SEC(NL), .SAVER_SEC(SV)) dut_u (
    .i_core_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_keys(fosc_keys_t'(keys)), .i_gw_seen(gw_up), .i_net_seen(net_up),
    .i_overload(ovl), .i_fuse_blown(fuse), .i_fan_run(run), .o_fan_on(fan_on), .o_warn_led(led),
    .o_warn_event(evt), .o_led_cycle(ledc), .o_disp(disp));
  fosc_starters_model #(.N_CH(NC)) far_u (.i_core_clk(clk), .i_resetn(rstn), .i_fan_on(fan_on),
    .i_trip(trip), .i_fuse(fuse_cmd), .o_run(run), .o_overload(ovl), .o_fuse_blown(fuse));

  always #20 clk = ~clk;
  // sticky flag for the one-cycle upstream report
  always @(posedge clk) begin
    evt_seen <= rstn && (evt_seen === 1'b1 || evt === 1'b1);
  end

  // -------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // trailing idle edge keeps two strobes from landing in one time step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, exp)
    @(posedge clk);
  endtask
  // a blank screen swallows the first press, so press twice then
  task automatic press(input int b);
    int k;
    k = (disp.blank === 1'b1) ? 2 : 1;
    repeat (k) begin
      keys[b] <= 1'b1;
      @(posedge clk);
      keys[b] <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic wait_out(input logic [NC-1:0] exp, input int lo, input int hi);
    int c;
    c = 0;
    while (fan_on !== exp && c <= hi) begin
      @(posedge clk);
      c++;
    end
    if (c > hi) begin
      miscompares++;
      $display("BAD %0t: outputs never reached %0h", $time, exp);
      test_done();
    end else begin
      `CHK(c >= lo, 1'b1)
    end
  endtask

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    clk = 0; rstn = 0; wr = 0; rd = 0; addr = '0; wdata = '0; keys = '0; gw_up = 1; net_up = 1;
    trip = '0; fuse_cmd = '0; compares = 0; miscompares = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk_reg(REG_AUTO_DLY, 32'h0000000a);
    chk_reg(REG_MAN_DLY, 32'h0000000a);
    chk_reg(REG_STATUS, 32'h00000016);
    wr_reg(REG_STATUS, 32'hffffffff);
    chk_reg(REG_STATUS, 32'h00000016);
    chk_reg(8'h24, 32'h00000000);
    wr_reg(REG_AUTO_DLY, 32'h00000002);
    wr_reg(REG_REMOTE_CMD, 32'h00000005);
    wait_out(6'h01, 0, 6);
    wait_out(6'h05, 2 * TK, 3 * TK + 4);
    chk_reg(REG_DIAG_OUT, 32'h00000005);
    chk_reg(REG_DIAG_IN, 32'h00000005);
    wr_reg(REG_REMOTE_CMD, 32'h00000000);
    wait_out(6'h00, 0, 3);
    repeat (3 * TK) @(posedge clk);  // automatic stagger ends first
    press(K_MODE);
    `CHK(disp.manual, 1'b1)
    wait_out(6'h01, 0, 6);
    wait_out(6'h03, DELAY_MIN_S * TK, (DELAY_MIN_S + 1) * TK + 4);
    press(K_MODE);
    `CHK(disp.manual, 1'b0)
    wait_out(6'h00, 0, 3);
    // delay edit: raise tens, store, then drop below the floor with wrap
    press(K_RIGHT);
    `CHK(disp.page, PG_DELAY)
    press(K_ENTER); press(K_LEFT); press(K_UP);
    `CHK(disp.editing, 1'b1)
    `CHK(disp.digits, 12'h020)
    press(K_ENTER);
    chk_reg(REG_MAN_DLY, 32'd20);
    press(K_ENTER); press(K_LEFT); press(K_DOWN); press(K_DOWN); press(K_RIGHT); press(K_DOWN);
    `CHK(disp.digits, 12'h009)
    press(K_ENTER);
    chk_reg(REG_MAN_DLY, 32'd10);
    press(K_LEFT);
    press(K_DOWN);
    `CHK(disp.page, PG_DIAG)
    press(K_UP);
    // warnings: overload ch1 and blown fuse ch3, then clear one at a time
    trip <= 6'h02; fuse_cmd <= 6'h08;
    chk_reg(REG_DIAG_FUSE, 32'h00000008);
    trip <= '0; fuse_cmd <= '0;
    chk_reg(REG_WARN, 32'h00080002);
    `CHK(led, 1'b1)
    `CHK(evt_seen, 1'b1)
    press(K_CLR1);
    chk_reg(REG_WARN, 32'h00080000);
    `CHK(led, 1'b1)
    press(K_CLR1);
    chk_reg(REG_WARN, 32'h00000000);
    `CHK(led, 1'b0)
    trip <= 6'h04;
    @(posedge clk);
    press(K_CLRA);
    chk_reg(REG_WARN, 32'h00000004);
    trip <= '0;
    press(K_CLRA);
    chk_reg(REG_WARN, 32'h00000000);
    trip <= 6'h11;
    @(posedge clk);
    trip <= '0;
    press(K_CLR);
    chk_reg(REG_WARN, 32'h00000000);
    // screen saver with an output running
    wr_reg(REG_REMOTE_CMD, 32'h00000001);
    n = 0;
    while (disp.blank !== 1'b1 && n < (SV + 2) * TK) begin
      @(posedge clk);
      n++;
    end
    `CHK(disp.blank, 1'b1)
    `CHK(n >= (SV - 2) * TK, 1'b1)
    repeat (2 * TK) @(posedge clk);
    `CHK($onehot(ledc), 1'b1)
    `CHK(fan_on, 6'h01)
    keys[K_DOWN] <= 1'b1;
    @(posedge clk);
    keys[K_DOWN] <= 1'b0;
    @(posedge clk);
    `CHK(disp.blank, 1'b0)
    `CHK(disp.page, PG_HOME)
    // network loss, shutdown, resume, manual bypass
    gw_up <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(disp.no_gateway, 1'b1)
    wait_out(6'h00, (NL - 1) * TK - 2, (NL + 1) * TK + 4);
    chk_reg(REG_STATUS, 32'h0000001c);
    gw_up <= 1'b1;
    wait_out(6'h01, 0, 6);
    net_up <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(disp.no_network, 1'b1)
    press(K_MODE);
    repeat ((NL + 3) * TK) @(posedge clk);
    `CHK(fan_on[0], 1'b1)
    press(K_MODE);
    net_up <= 1'b1;
    wr_reg(REG_RSSI, 32'h00000040);
    `CHK(disp.pct, 8'h40)
    `CHK(disp.icon, 3'h3)
    chk_reg(REG_RSSI, 32'h00000040);
    test_done();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("BAD %0t: run did not finish", $time);
    test_done();
  end
endmodule

bind fosc_controller fosc_controller_asserts #(.N_CH(N_CH), .TICK_CYC(TICK_CYC), .NETLOSS_SEC(NETLOSS_SEC),
  .SAVER_SEC(SAVER_SEC)) chk_u (.i_core_clk, .i_resetn, .i_rd, .o_rdata, .i_keys, .i_gw_seen, .i_net_seen,
  .i_overload, .i_fuse_blown, .o_fan_on, .o_warn_led, .o_warn_event, .o_led_cycle, .o_disp);

`default_nettype wire
